/* rtl/bstp_pkg.sv */
`default_nettype none
package bstp_pkg;

   // Test access port controller states, one-hot
   typedef enum logic [15:0] {
      ST_RESET    = 16'h0001,
      ST_IDLE     = 16'h0002,
      ST_SEL_DR   = 16'h0004,
      ST_CAP_DR   = 16'h0008,
      ST_SH_DR    = 16'h0010,
      ST_EX1_DR   = 16'h0020,
      ST_PA_DR    = 16'h0040,
      ST_EX2_DR   = 16'h0080,
      ST_UPD_DR   = 16'h0100,
      ST_SEL_INS  = 16'h0200,
      ST_CAP_INS  = 16'h0400,
      ST_SH_INS   = 16'h0800,
      ST_EX1_INS  = 16'h1000,
      ST_PA_INS   = 16'h2000,
      ST_EX2_INS  = 16'h4000,
      ST_UPD_INS  = 16'h8000
   } bstp_state_e;

   typedef struct packed {
      bstp_state_e st;
   } bstp_fsm_s;

   localparam int unsigned INS_W = 4;
   localparam int unsigned ID_W  = 32;

   localparam logic [INS_W-1:0] OP_DRIVE_CELLS     = 4'h0;
   localparam logic [INS_W-1:0] OP_SAMPLE_PRELOAD  = 4'h1;
   localparam logic [INS_W-1:0] OP_READ_IDENTITY   = 4'h2;
   localparam logic [INS_W-1:0] OP_FLOAT_OUTPUTS   = 4'h3;
   localparam logic [INS_W-1:0] OP_CLAMP           = 4'h8;
   localparam logic [INS_W-1:0] OP_CAPTURE_DEFAULT = 4'hD;
   localparam logic [INS_W-1:0] OP_BYPASS          = 4'hF;
   localparam logic [INS_W-1:0] OP_AFTER_RESET     = OP_READ_IDENTITY;

   // Identification word layout
   localparam int unsigned ID_VER_LSB  = 28;
   localparam int unsigned ID_VER_W    = 4;
   localparam int unsigned ID_PART_LSB = 12;
   localparam int unsigned ID_PART_W   = 16;
   localparam int unsigned ID_VEND_LSB = 1;
   localparam int unsigned ID_VEND_W   = 11;
   localparam logic        ID_PRESENT  = 1'b1;

   localparam logic [1:0]  SYNC_RST_LO = 2'h0;
   localparam logic [1:0]  SYNC_RST_HI = 2'h3;

endpackage : bstp_pkg
`default_nettype wire

/* rtl/bstp_tap_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bstp_tap_if;
   logic                  tck_rise;
   logic                  tms;
   logic                  tap_rst;
   bstp_pkg::bstp_state_e state;

   modport fsm  (input tck_rise, input tms, input tap_rst, output state);
   modport core (output tck_rise, output tms, output tap_rst, input state);
endinterface : bstp_tap_if
`default_nettype wire

/* rtl/bstp_tap_fsm.sv */
`timescale 1ns/1ps
`default_nettype none
module bstp_tap_fsm (
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   bstp_tap_if.fsm   tap
);
   bstp_pkg::bstp_fsm_s q;
   bstp_pkg::bstp_fsm_s d;

   assign tap.state = q.st;

   always_comb begin
      d = q;
      if (tap.tap_rst) begin
         d.st = bstp_pkg::ST_RESET;
      end else if (tap.tck_rise) begin
         unique case (q.st)
            bstp_pkg::ST_RESET:   d.st = tap.tms ? bstp_pkg::ST_RESET   : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_IDLE:    d.st = tap.tms ? bstp_pkg::ST_SEL_DR  : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_SEL_DR:  d.st = tap.tms ? bstp_pkg::ST_SEL_INS : bstp_pkg::ST_CAP_DR;
            bstp_pkg::ST_CAP_DR:  d.st = tap.tms ? bstp_pkg::ST_EX1_DR  : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_SH_DR:   d.st = tap.tms ? bstp_pkg::ST_EX1_DR  : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_EX1_DR:  d.st = tap.tms ? bstp_pkg::ST_UPD_DR  : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_PA_DR:   d.st = tap.tms ? bstp_pkg::ST_EX2_DR  : bstp_pkg::ST_PA_DR;
            bstp_pkg::ST_EX2_DR:  d.st = tap.tms ? bstp_pkg::ST_UPD_DR  : bstp_pkg::ST_SH_DR;
            bstp_pkg::ST_UPD_DR:  d.st = tap.tms ? bstp_pkg::ST_SEL_DR  : bstp_pkg::ST_IDLE;
            bstp_pkg::ST_SEL_INS: d.st = tap.tms ? bstp_pkg::ST_RESET   : bstp_pkg::ST_CAP_INS;
            bstp_pkg::ST_CAP_INS: d.st = tap.tms ? bstp_pkg::ST_EX1_INS : bstp_pkg::ST_SH_INS;
            bstp_pkg::ST_SH_INS:  d.st = tap.tms ? bstp_pkg::ST_EX1_INS : bstp_pkg::ST_SH_INS;
            bstp_pkg::ST_EX1_INS: d.st = tap.tms ? bstp_pkg::ST_UPD_INS : bstp_pkg::ST_PA_INS;
            bstp_pkg::ST_PA_INS:  d.st = tap.tms ? bstp_pkg::ST_EX2_INS : bstp_pkg::ST_PA_INS;
            bstp_pkg::ST_EX2_INS: d.st = tap.tms ? bstp_pkg::ST_UPD_INS : bstp_pkg::ST_SH_INS;
            bstp_pkg::ST_UPD_INS: d.st = tap.tms ? bstp_pkg::ST_SEL_DR  : bstp_pkg::ST_IDLE;
            default:              d.st = bstp_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q.st <= bstp_pkg::ST_RESET;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   a_state_only_on_edge: assert property (
      (!tap.tck_rise && !tap.tap_rst) |=> $stable(q.st))
      else $error("tap state moved without a test clock rise");

   a_exit_shift_dr: assert property (
      (q.st == bstp_pkg::ST_SH_DR && tap.tck_rise && tap.tms && !tap.tap_rst)
         |=> q.st == bstp_pkg::ST_EX1_DR)
      else $error("shift-dr did not exit on mode select high");

   a_test_reset_hold: assert property (
      tap.tap_rst |=> q.st == bstp_pkg::ST_RESET)
      else $error("test reset did not force the reset state");

endmodule : bstp_tap_fsm
`default_nettype wire

/* rtl/bstp_top.sv */
// Operation
// - Code 0000 drives cell contents onto outputs; boundary chain is the path.
// - Code 0001 selects boundary chain and samples inputs and outputs into cells.
// - Code 0001 also lets serial data preload the cells for later driving.
// - Code 0010 loads the 32-bit identity word and selects it as the path.
// - Code 0011 floats every pad output driver and selects the bypass bit.
// - Code 1000 keeps driving cell contents while the bypass bit is the path.
// - Capture of the instruction path always loads code 1101, low bits 01.
// - Code 1111 shortens the serial path to the single bypass bit.
// - Identity word: version 31:28, part 27:12, vendor 11:1, bit 0 set.
// - Cells cover all pin inputs and all pad data outputs; the pad enable and serial out have none.
// - Test logic resets itself at power up; test reset input is optional.
`timescale 1ns/1ps
`default_nettype none
module bstp_top #(
   parameter int unsigned         N_IN       = 8,
   parameter int unsigned         N_OUT      = 8,
   parameter logic [3:0]          ID_VERSION = 4'h1,     // Arbitrary value
   parameter logic [15:0]         ID_PART    = 16'hA5C1, // Arbitrary value
   parameter logic [10:0]         ID_VENDOR  = 11'h4B5   // Arbitrary value
) (
   input  wire logic              mclk_i,
   input  wire logic              nrst_i,
   input  wire logic              tck_i,
   input  wire logic              tms_i,
   input  wire logic              tdi_i,
   input  wire logic              trst_n_i,
   output logic                   tdo_o,
   output logic                   tdo_oe_o,
   input  wire logic [N_IN-1:0]   pin_in_i,
   input  wire logic [N_OUT-1:0]  core_out_i,
   input  wire logic              core_oe_i,
   output logic      [N_OUT-1:0]  pad_out_o,
   output logic                   pad_oe_o
);
   localparam int unsigned N_BC = N_IN + N_OUT;
   localparam int unsigned INW  = bstp_pkg::INS_W;
   localparam int unsigned IDW  = bstp_pkg::ID_W;

   typedef struct packed {
      logic [1:0]         tck_s;
      logic [1:0]         tms_s;
      logic [1:0]         tdi_s;
      logic [1:0]         trst_s;
      logic [N_IN-1:0]    pin_s1;
      logic [N_IN-1:0]    pin_s2;
      logic               tck_prev;
      logic [INW-1:0]     ins_sr;
      logic [INW-1:0]     ins_q;
      logic               byp;
      logic [IDW-1:0]     id_sr;
      logic [N_BC-1:0]    bc_sr;
      logic [N_BC-1:0]    bc_upd;
      logic               tdo;
      logic               tdo_oe;
      logic [N_OUT-1:0]   pad_out;
      logic               pad_oe;
   } bstp_core_s;

   localparam logic [IDW-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_VENDOR,
                                         bstp_pkg::ID_PRESENT};

   // Reserved codes fall back to the bypass bit
   function automatic logic sel_boundary(input logic [INW-1:0] ins);
      sel_boundary = (ins == bstp_pkg::OP_DRIVE_CELLS) ||
                     (ins == bstp_pkg::OP_SAMPLE_PRELOAD);
   endfunction : sel_boundary

   function automatic logic sel_identity(input logic [INW-1:0] ins);
      sel_identity = (ins == bstp_pkg::OP_READ_IDENTITY);
   endfunction : sel_identity

   function automatic logic drives_cells(input logic [INW-1:0] ins);
      drives_cells = (ins == bstp_pkg::OP_DRIVE_CELLS) || (ins == bstp_pkg::OP_CLAMP);
   endfunction : drives_cells

   bstp_core_s q;
   bstp_core_s d;

   bstp_tap_if tap_bus ();

   bstp_tap_fsm u_fsm (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .tap    (tap_bus)
   );

   logic tck_rise;
   logic tck_fall;
   logic tdi_v;
   bstp_pkg::bstp_state_e st;

   assign tck_rise         = q.tck_s[1] && !q.tck_prev;
   assign tck_fall         = !q.tck_s[1] && q.tck_prev;
   assign tdi_v            = q.tdi_s[1];
   assign st               = tap_bus.state;
   assign tap_bus.tck_rise = tck_rise;
   assign tap_bus.tms      = q.tms_s[1];
   assign tap_bus.tap_rst  = !q.trst_s[1];

   always_comb begin
      d          = q;
      d.tck_s    = {q.tck_s[0], tck_i};
      d.tms_s    = {q.tms_s[0], tms_i};
      d.tdi_s    = {q.tdi_s[0], tdi_i};
      d.trst_s   = {q.trst_s[0], trst_n_i};
      d.pin_s1   = pin_in_i;
      d.pin_s2   = q.pin_s1;
      d.tck_prev = q.tck_s[1];

      if (tck_rise) begin
         unique case (st)
            bstp_pkg::ST_RESET: begin
               d.ins_q = bstp_pkg::OP_AFTER_RESET;
            end
            bstp_pkg::ST_CAP_INS: begin
               d.ins_sr = bstp_pkg::OP_CAPTURE_DEFAULT;
            end
            bstp_pkg::ST_SH_INS: begin
               d.ins_sr = {tdi_v, q.ins_sr[INW-1:1]};
            end
            bstp_pkg::ST_UPD_INS: begin
               d.ins_q = q.ins_sr;
            end
            bstp_pkg::ST_CAP_DR: begin
               if (sel_boundary(q.ins_q)) begin
                  d.bc_sr = {q.pad_out, q.pin_s2};
               end else if (sel_identity(q.ins_q)) begin
                  d.id_sr = ID_WORD;
               end else begin
                  d.byp = 1'b0;
               end
            end
            bstp_pkg::ST_SH_DR: begin
               if (sel_boundary(q.ins_q)) begin
                  d.bc_sr = {tdi_v, q.bc_sr[N_BC-1:1]};
               end else if (sel_identity(q.ins_q)) begin
                  d.id_sr = {tdi_v, q.id_sr[IDW-1:1]};
               end else begin
                  d.byp = tdi_v;
               end
            end
            bstp_pkg::ST_UPD_DR: begin
               if (sel_boundary(q.ins_q)) begin
                  d.bc_upd = q.bc_sr;
               end
            end
            default: begin
            end
         endcase
      end

      // Serial out moves on the falling edge so the far end samples a settled bit
      if (tck_fall) begin
         d.tdo_oe = (st == bstp_pkg::ST_SH_DR) || (st == bstp_pkg::ST_SH_INS);
         if (st == bstp_pkg::ST_SH_INS) begin
            d.tdo = q.ins_sr[0];
         end else if (sel_boundary(q.ins_q)) begin
            d.tdo = q.bc_sr[0];
         end else if (sel_identity(q.ins_q)) begin
            d.tdo = q.id_sr[0];
         end else begin
            d.tdo = q.byp;
         end
      end

      // Registered pad drive costs one cycle on the functional path
      if (q.ins_q == bstp_pkg::OP_FLOAT_OUTPUTS) begin
         d.pad_out = core_out_i;
         d.pad_oe  = 1'b0;
      end else if (drives_cells(q.ins_q)) begin
         d.pad_out = q.bc_upd[N_BC-1:N_IN];
         d.pad_oe  = 1'b1;
      end else begin
         d.pad_out = core_out_i;
         d.pad_oe  = core_oe_i;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q.tck_s    <= bstp_pkg::SYNC_RST_LO;
         q.tms_s    <= bstp_pkg::SYNC_RST_HI;
         q.tdi_s    <= bstp_pkg::SYNC_RST_HI;
         q.trst_s   <= bstp_pkg::SYNC_RST_HI;
         q.pin_s1   <= '0;
         q.pin_s2   <= '0;
         q.tck_prev <= 1'b0;
         q.ins_sr   <= bstp_pkg::OP_CAPTURE_DEFAULT;
         q.ins_q    <= bstp_pkg::OP_AFTER_RESET;
         q.byp      <= 1'b0;
         q.id_sr    <= '0;
         q.bc_sr    <= '0;
         q.bc_upd   <= '0;
         q.tdo      <= 1'b0;
         q.tdo_oe   <= 1'b0;
         q.pad_out  <= '0;
         q.pad_oe   <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign tdo_o     = q.tdo;
   assign tdo_oe_o  = q.tdo_oe;
   assign pad_out_o = q.pad_out;
   assign pad_oe_o  = q.pad_oe;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   a_capture_default_code: assert property (
      (tck_rise && st == bstp_pkg::ST_CAP_INS) |=> q.ins_sr == 4'hD)
      else $error("instruction capture did not load the default code");

   a_float_outputs_off: assert property (
      (q.ins_q == bstp_pkg::OP_FLOAT_OUTPUTS) |=> !pad_oe_o)
      else $error("outputs not floated under the float instruction");

   a_drive_cell_pads: assert property (
      drives_cells(q.ins_q) |=> (pad_oe_o && pad_out_o == $past(q.bc_upd[N_BC-1:N_IN])))
      else $error("pads do not show the update cells");

   a_identity_load: assert property (
      (tck_rise && st == bstp_pkg::ST_CAP_DR && q.ins_q == 4'h2)
         |=> (q.id_sr[0] && q.id_sr[31:28] == ID_VERSION && q.id_sr[11:1] == ID_VENDOR
              && q.id_sr[27:12] == ID_PART))
      else $error("identity word not loaded on capture");

   a_sample_inputs: assert property (
      (tck_rise && st == bstp_pkg::ST_CAP_DR && q.ins_q == 4'h1)
         |=> q.bc_sr[N_IN-1:0] == $past(q.pin_s2))
      else $error("sample did not capture the input pins");

   a_preload_update: assert property (
      (tck_rise && st == bstp_pkg::ST_UPD_DR && sel_boundary(q.ins_q))
         |=> q.bc_upd == $past(q.bc_sr))
      else $error("update did not take the shifted cells");

   a_bypass_shift: assert property (
      (tck_rise && st == bstp_pkg::ST_SH_DR && q.ins_q == 4'hF) |=> q.byp == $past(tdi_v))
      else $error("bypass bit did not take serial in");

   a_serial_out_enable: assert property (
      (tck_fall && (st == bstp_pkg::ST_SH_DR || st == bstp_pkg::ST_SH_INS)) |=> tdo_oe_o [*2])
      else $error("serial out not enabled in a shift state");

   a_serial_out_idle: assert property (
      (tck_fall && !(st == bstp_pkg::ST_SH_DR || st == bstp_pkg::ST_SH_INS)) |=> !tdo_oe_o)
      else $error("serial out enabled outside the shift states");

   a_tdo_stands: assert property (
      !tck_fall |=> ($stable(tdo_o) && $stable(tdo_oe_o)))
      else $error("serial out changed without a test clock fall");

   a_tdo_ins_bit: assert property (
      (tck_fall && st == bstp_pkg::ST_SH_INS) |=> tdo_o == $past(q.ins_sr[0]))
      else $error("serial out does not show the instruction path");

   a_tdo_id_bit: assert property (
      (tck_fall && st == bstp_pkg::ST_SH_DR && sel_identity(q.ins_q))
         |=> tdo_o == $past(q.id_sr[0]))
      else $error("serial out does not show the identity path");

   a_tdo_bypass_bit: assert property (
      (tck_fall && st == bstp_pkg::ST_SH_DR && !sel_boundary(q.ins_q) && !sel_identity(q.ins_q))
         |=> tdo_o == $past(q.byp))
      else $error("serial out does not show the bypass bit");

   a_ins_shift_in: assert property (
      (tck_rise && st == bstp_pkg::ST_SH_INS)
         |=> q.ins_sr == {$past(tdi_v), $past(q.ins_sr[INW-1:1])})
      else $error("instruction path did not shift serial in");

   a_ins_update: assert property (
      (tck_rise && st == bstp_pkg::ST_UPD_INS) |=> q.ins_q == $past(q.ins_sr))
      else $error("instruction update did not take the shifted code");

   a_reset_ins_code: assert property (
      (tck_rise && st == bstp_pkg::ST_RESET) |=> q.ins_q == bstp_pkg::OP_AFTER_RESET)
      else $error("test reset state did not restore the identity instruction");

   a_bypass_capture: assert property (
      (tck_rise && st == bstp_pkg::ST_CAP_DR && !sel_boundary(q.ins_q) && !sel_identity(q.ins_q))
         |=> !q.byp)
      else $error("bypass bit did not capture zero");

   a_boundary_shift: assert property (
      (tck_rise && st == bstp_pkg::ST_SH_DR && sel_boundary(q.ins_q))
         |=> q.bc_sr == {$past(tdi_v), $past(q.bc_sr[N_BC-1:1])})
      else $error("boundary chain did not shift serial in");

   a_identity_shift: assert property (
      (tck_rise && st == bstp_pkg::ST_SH_DR && sel_identity(q.ins_q))
         |=> q.id_sr == {$past(tdi_v), $past(q.id_sr[IDW-1:1])})
      else $error("identity path did not shift serial in");

   a_sample_outputs: assert property (
      (tck_rise && st == bstp_pkg::ST_CAP_DR && q.ins_q == bstp_pkg::OP_SAMPLE_PRELOAD)
         |=> q.bc_sr[N_BC-1:N_IN] == $past(q.pad_out))
      else $error("sample did not capture the output pads");

   a_update_holds: assert property (
      !(tck_rise && st == bstp_pkg::ST_UPD_DR) |=> $stable(q.bc_upd))
      else $error("update cells moved outside update-dr");

   a_functional_pads: assert property (
      (q.ins_q != bstp_pkg::OP_FLOAT_OUTPUTS && !drives_cells(q.ins_q))
         |=> (pad_oe_o == $past(core_oe_i) && pad_out_o == $past(core_out_i)))
      else $error("pads do not follow the core outside test drive");

endmodule : bstp_top
`default_nettype wire

/* dv/bstp_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bstp_ctl_model (
   input  wire logic mclk_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o
);
   logic oe_all;

   initial begin
      tck_o  = 1'b0;
      tms_o  = 1'b1;
      tdi_o  = 1'b0;
      oe_all = 1'b1;
   end

   // 64 ns period, 8 mclk low then 8 high; tck rests low between scans
   task automatic step(input logic ms, input logic di, output logic dout);
      tms_o = ms;
      tdi_o = di;
      repeat (8) @(negedge mclk_i);
      // A released line reads inverted so a missing enable cannot pass
      dout  = tdo_oe_i ? tdo_i : !tdo_i;
      tck_o = 1'b1;
      repeat (8) @(negedge mclk_i);
      tck_o = 1'b0;
   endtask : step

   task automatic reset_tap();
      logic d;
      repeat (5) step(1'b1, 1'($urandom), d);
      step(1'b0, 1'($urandom), d);
   endtask : reset_tap

   // From idle through a whole scan back to idle; tdi toggles randomly off shift
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic d;
      dout   = '0;
      oe_all = 1'b1;
      step(1'b1, 1'($urandom), d);
      if (ir) begin
         step(1'b1, 1'($urandom), d);
      end
      step(1'b0, 1'($urandom), d);
      step(1'b0, 1'($urandom), d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
         oe_all &= tdo_oe_i;
      end
      step(1'b1, 1'($urandom), d);
      step(1'b0, 1'($urandom), d);
   endtask : scan
endmodule : bstp_ctl_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int unsigned NI   = 8;
   localparam int unsigned NO   = 8;
   localparam logic [3:0]  VER  = 4'h6;     // Arbitrary value
   localparam logic [15:0] PART = 16'h1234; // Arbitrary value
   localparam logic [10:0] VEND = 11'h2AB;  // Arbitrary value

   logic          mclk, nrst, tck, tms, tdi, trst_n, tdo, tdo_oe, core_oe, pad_oe;
   logic [NI-1:0] pin_in;
   logic [NO-1:0] core_out, pad_out;
   logic [31:0]   dout, din, seed;
   logic [15:0]   cells;
   logic [3:0]    codes [6];
   int            n_fail, checks;

   bstp_top #(.N_IN(NI), .N_OUT(NO), .ID_VERSION(VER), .ID_PART(PART), .ID_VENDOR(VEND)) i_dut (
      .mclk_i(mclk), .nrst_i(nrst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
      .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in),
      .core_out_i(core_out), .core_oe_i(core_oe), .pad_out_o(pad_out), .pad_oe_o(pad_oe));

   bstp_ctl_model i_ctl (.mclk_i(mclk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
                         .tms_o(tms), .tdi_o(tdi));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   function automatic logic [31:0] id_word();
      return {VER, PART, VEND, 1'b1};
   endfunction : id_word

   function automatic logic oe_exp(input logic [3:0] code, input logic oe);
      return (code == 4'h3) ? 1'b0 : (code == 4'h8) ? 1'b1 : oe;
   endfunction : oe_exp

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic pads(input logic [3:0] code);
      core_out = NO'($urandom);
      core_oe  = 1'($urandom);
      repeat (2) @(negedge mclk);
      chk("pad_oe", 32'(oe_exp(code, core_oe)), 32'(pad_oe));
      if (code != 4'h3) begin
         chk("pad_out", 32'((code == 4'h8) ? cells[15:8] : core_out), 32'(pad_out));
      end
   endtask : pads

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      #100000;
      n_fail++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      nrst     = 1'b0;
      trst_n   = 1'b1;
      pin_in   = '0;
      core_out = '0;
      core_oe  = 1'b0;
      n_fail   = 0;
      checks   = 0;
      seed     = $urandom(32'hCC5C);
      codes    = '{4'h3, 4'h8, 4'hF, 4'hD, 4'h8, 4'h3};
      repeat (12) @(negedge mclk);
      chk("tdo_oe in reset", 32'h0, 32'(tdo_oe));
      chk("pad_oe in reset", 32'h0, 32'(pad_oe));
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      i_ctl.reset_tap();
      i_ctl.scan(1'b0, 32, $urandom, dout);
      chk("identity", id_word(), dout);
      chk("tdo_oe in shift", 32'h1, 32'(i_ctl.oe_all));
      $display("test identity done");
      pin_in   = NI'($urandom);
      core_out = NO'($urandom);
      core_oe  = 1'b1;
      i_ctl.scan(1'b1, 4, 32'(bstp_pkg::OP_SAMPLE_PRELOAD), dout);
      chk("captured ins", 32'hD, {28'h0, dout[3:0]});
      din = $urandom;
      i_ctl.scan(1'b0, 16, din, dout);
      chk("sample", {16'h0, core_out, pin_in}, dout);
      cells = din[15:0];
      i_ctl.scan(1'b1, 4, 32'(bstp_pkg::OP_DRIVE_CELLS), dout);
      repeat (2) @(negedge mclk);
      chk("preloaded out", 32'(cells[15:8]), 32'(pad_out));
      chk("drive oe", 32'h1, 32'(pad_oe));
      din = $urandom;
      i_ctl.scan(1'b0, 16, din, dout);
      chk("drive capture", {16'h0, cells[15:8], pin_in}, dout);
      cells = din[15:0];
      repeat (2) @(negedge mclk);
      chk("drive update", 32'(cells[15:8]), 32'(pad_out));
      $display("test boundary done");
      foreach (codes[k]) begin
         i_ctl.scan(1'b1, 4, 32'(codes[k]), dout);
         chk("captured ins", 32'hD, {28'h0, dout[3:0]});
         din = $urandom;
         i_ctl.scan(1'b0, 8, din, dout);
         chk("bypass path", {24'h0, din[6:0], 1'b0}, dout);
         pads(codes[k]);
      end
      $display("test bypass codes done");
      trst_n = 1'b0;
      repeat (8) @(negedge mclk);
      trst_n = 1'b1;
      repeat (4) @(negedge mclk);
      i_ctl.step(1'b0, 1'b0, dout[0]);
      i_ctl.scan(1'b0, 32, $urandom, dout);
      chk("identity after test reset", id_word(), dout);
      $display("test reset pin done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
